// >>> verilog/cpr_pkg.sv
// Constants, encodings and carriers for the processor register set.
// How it works
// - Working register feeds ALU, survives reset
// - Reset clears upper pointer byte, keeps low
// - Indexed accesses use upper:low pointer pair
// - Some ops touch only the low pointer byte
// - Stack pointer addresses next free stack slot
// - Reset loads stack pointer with 0x00FF
// - Stack adjust adds sign-extended immediate
// - Stack low reload changes low byte only
// - Program counter advances one per fetch
// - Jumps and branches load new address
// - Reset loads counter from top vector bytes
// - Flag bits 6 and 5 always read one
// - Overflow flag tracks signed overflow, signed branches
// - Nibble carry from bit 3 on adds
// - Decimal adjust corrects sums using flags
// - Mask flag blocks maskable interrupts
// - Mask set after stacking, before handler
// - No interrupt right after unmasking instruction
// - Sign flag follows result top bit
// - Zero flag set on all-zero result
// - Carry flag on carry, borrow, shifts, tests
// - Interrupt pushes pcl, pch, low, work, flags
package cpr_pkg;

  // Flag positions
  localparam int unsigned F_V = 7;
  localparam int unsigned F_H = 4;
  localparam int unsigned F_I = 3;
  localparam int unsigned F_N = 2;
  localparam int unsigned F_Z = 1;
  localparam int unsigned F_C = 0;
  localparam logic [7:0] CCR_ONES = 8'h60;
  localparam logic [7:0] CCR_RST = 8'h68;
  localparam logic [7:0] FM_NONE = 8'h00;
  localparam logic [7:0] FM_C = 8'h01;
  localparam logic [7:0] FM_I = 8'h08;
  localparam logic [7:0] FM_NZC = 8'h07;
  localparam logic [7:0] FM_VNZ = 8'h86;
  localparam logic [7:0] FM_VNZC = 8'h87;
  localparam logic [7:0] FM_ARITH = 8'h97;
  localparam logic [7:0] FM_ALL = 8'hff;

  // Reset values and vectors
  localparam logic [7:0] HI_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h00ff;
  localparam logic [7:0] SP_LOW_RELOAD = 8'hff;
  localparam logic [15:0] VEC_HI_ADDR = 16'hfffe;
  localparam logic [15:0] VEC_LO_ADDR = 16'hffff;
  localparam logic [2:0] PUSH_LAST = 3'h4;

  // Register window on the bus
  localparam logic [11:0] RA_WORK = 12'h000;
  localparam logic [11:0] RA_PHI = 12'h004;
  localparam logic [11:0] RA_PLO = 12'h008;
  localparam logic [11:0] RA_SP = 12'h00c;
  localparam logic [11:0] RA_PC = 12'h010;
  localparam logic [11:0] RA_CCR = 12'h014;
  localparam logic [11:0] RA_STAT = 12'h018;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_AND, OP_ORA, OP_EOR,
    OP_LDA, OP_STA, OP_LDX, OP_STX, OP_LDHX, OP_CLRX, OP_INCX, OP_DECX,
    OP_COMX, OP_NEGX, OP_LSLX, OP_LSRX, OP_ROLX, OP_RORX, OP_DAA, OP_TAP,
    OP_TPA, OP_TAX, OP_TXA, OP_SEI, OP_CLI, OP_BITTST, OP_FETCH, OP_JUMP,
    OP_BRA, OP_BLT, OP_BGE, OP_AIS, OP_RSP, OP_IRQ
  } cpr_op_t;

  typedef enum logic [3:0] {
    ST_VEC_HI = 4'h1,
    ST_VEC_LO = 4'h2,
    ST_RUN = 4'h4,
    ST_STACK = 4'h8
  } cpr_state_t;

  typedef struct packed {
    cpr_op_t code;
    logic [7:0] opd8;
    logic [15:0] opd16;
  } cpr_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } cpr_push_t;

endpackage

// >>> verilog/cpr_regs.sv
// Processor programmer-visible register set with stacking, vector load and APB view.
`timescale 1ns/10ps
module cpr_regs
  import cpr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB register view
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operation requests from the core sequencer
  input wire logic op_valid,
  input wire cpr_req_t op_req,
  output logic op_ready,
  input wire logic insn_boundary,
  // Vector read port
  output logic vec_rd_req,
  output logic [15:0] vec_rd_addr,
  input wire logic vec_rd_valid,
  input wire logic [7:0] vec_rd_data,
  // Stack write port
  output cpr_push_t push,
  // Register contents
  output logic [7:0] working_register,
  output logic [15:0] index_pointer,
  output logic [15:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] condition_code_reg,
  output logic irq_allowed
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] work_r;
  logic [7:0] plo_r;
  logic [7:0] phi_r;
  logic [15:0] sp_r;
  logic [15:0] pc_r;
  logic [7:0] ccr_r;
  logic shadow_r;
  logic irq_ok_r;
  cpr_state_t state_r;
  cpr_state_t state_nxt;
  logic [2:0] push_cnt_r;
  cpr_push_t push_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic run_op;
  logic bus_wr;
  logic [8:0] sum9;
  logic [8:0] dif9;
  logic cin;
  logic [7:0] r8;
  logic [15:0] r16;
  logic wide;
  logic nz_from_res;
  logic [7:0] fv;
  logic [7:0] fm;
  logic a_wr;
  logic x_wr;
  logic hx_wr;
  logic [7:0] ccr_nxt;
  logic shadow_nxt;
  logic [7:0] daa_corr;
  logic daa_c;
  logic br_take;

  assign run_op = op_valid && (state_r == ST_RUN);
  assign bus_wr = psel && penable && pready_r && pwrite && !pslverr_r;
  assign cin = (op_req.code == OP_ADC || op_req.code == OP_SBC) ? ccr_r[F_C] : 1'b0;
  assign sum9 = {1'b0, work_r} + {1'b0, op_req.opd8} + {8'h00, cin};
  assign dif9 = {1'b0, work_r} - {1'b0, op_req.opd8} - {8'h00, cin};

  ////////////////////////////////////////////////////////////////////////
  // Result and flag generation
  always_comb begin
    r8 = 8'h00;
    r16 = 16'h0000;
    wide = 1'b0;
    nz_from_res = 1'b0;
    fv = ccr_r;
    fm = FM_NONE;
    a_wr = 1'b0;
    x_wr = 1'b0;
    hx_wr = 1'b0;
    daa_corr = 8'h00;
    daa_c = 1'b0;
    case (op_req.code)
      OP_ADD, OP_ADC: begin
        r8 = sum9[7:0];
        a_wr = 1'b1;
        nz_from_res = 1'b1;
        fv[F_V] = (work_r[7] & op_req.opd8[7] & ~r8[7]) |
                  (~work_r[7] & ~op_req.opd8[7] & r8[7]);
        fv[F_H] = (work_r[3] & op_req.opd8[3]) | (op_req.opd8[3] & ~r8[3]) |
                  (~r8[3] & work_r[3]);
        fv[F_C] = sum9[8];
        fm = FM_ARITH;
      end
      OP_SUB, OP_SBC, OP_CMP: begin
        r8 = dif9[7:0];
        a_wr = (op_req.code != OP_CMP);
        nz_from_res = 1'b1;
        fv[F_V] = (work_r[7] & ~op_req.opd8[7] & ~r8[7]) |
                  (~work_r[7] & op_req.opd8[7] & r8[7]);
        fv[F_C] = dif9[8];
        fm = FM_VNZC;
      end
      OP_AND, OP_ORA, OP_EOR, OP_LDA: begin
        case (op_req.code)
          OP_AND: r8 = work_r & op_req.opd8;
          OP_ORA: r8 = work_r | op_req.opd8;
          OP_EOR: r8 = work_r ^ op_req.opd8;
          default: r8 = op_req.opd8;
        endcase
        a_wr = 1'b1;
        nz_from_res = 1'b1;
        fv[F_V] = 1'b0;
        fm = FM_VNZ;
      end
      OP_STA, OP_STX, OP_LDX: begin
        // Stores only touch flags; the core drives memory
        r8 = (op_req.code == OP_STA) ? work_r :
             (op_req.code == OP_STX) ? plo_r : op_req.opd8;
        x_wr = (op_req.code == OP_LDX);
        nz_from_res = 1'b1;
        fv[F_V] = 1'b0;
        fm = FM_VNZ;
      end
      OP_LDHX: begin
        r16 = op_req.opd16;
        wide = 1'b1;
        hx_wr = 1'b1;
        nz_from_res = 1'b1;
        fv[F_V] = 1'b0;
        fm = FM_VNZ;
      end
      OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX, OP_LSLX, OP_LSRX,
      OP_ROLX, OP_RORX: begin
        x_wr = 1'b1;
        nz_from_res = 1'b1;
        fm = FM_VNZC;
        case (op_req.code)
          OP_CLRX: begin
            r8 = 8'h00;
            fv[F_V] = 1'b0;
            fm = FM_VNZ;
          end
          OP_INCX: begin
            r8 = plo_r + 8'h01;
            fv[F_V] = (plo_r == 8'h7f);
            fm = FM_VNZ;
          end
          OP_DECX: begin
            r8 = plo_r - 8'h01;
            fv[F_V] = (plo_r == 8'h80);
            fm = FM_VNZ;
          end
          OP_COMX: begin
            r8 = ~plo_r;
            fv[F_V] = 1'b0;
            fv[F_C] = 1'b1;
          end
          OP_NEGX: begin
            r8 = 8'h00 - plo_r;
            fv[F_V] = (plo_r == 8'h80);
            fv[F_C] = (plo_r != 8'h00);
          end
          OP_LSLX: begin
            r8 = {plo_r[6:0], 1'b0};
            fv[F_C] = plo_r[7];
            fv[F_V] = r8[7] ^ plo_r[7];
          end
          OP_LSRX: begin
            r8 = {1'b0, plo_r[7:1]};
            fv[F_C] = plo_r[0];
            fv[F_V] = plo_r[0];
          end
          OP_ROLX: begin
            r8 = {plo_r[6:0], ccr_r[F_C]};
            fv[F_C] = plo_r[7];
            fv[F_V] = r8[7] ^ plo_r[7];
          end
          default: begin
            r8 = {ccr_r[F_C], plo_r[7:1]};
            fv[F_C] = plo_r[0];
            fv[F_V] = ccr_r[F_C] ^ plo_r[0];
          end
        endcase
      end
      OP_DAA: begin
        if (ccr_r[F_H] || (work_r[3:0] > 4'h9)) begin
          daa_corr[3:0] = 4'h6;
        end
        if (ccr_r[F_C] || (work_r > 8'h99)) begin
          daa_corr[7:4] = 4'h6;
          daa_c = 1'b1;
        end
        r8 = work_r + daa_corr;
        a_wr = 1'b1;
        nz_from_res = 1'b1;
        fv[F_C] = daa_c;
        fm = FM_NZC;
      end
      OP_TAP: begin
        fv = work_r;
        fm = FM_ALL;
      end
      OP_TPA: begin
        r8 = ccr_r;
        a_wr = 1'b1;
      end
      OP_TAX: begin
        r8 = work_r;
        x_wr = 1'b1;
      end
      OP_TXA: begin
        r8 = plo_r;
        a_wr = 1'b1;
      end
      OP_SEI, OP_CLI: begin
        fv[F_I] = (op_req.code == OP_SEI);
        fm = FM_I;
      end
      OP_BITTST: begin
        fv[F_C] = op_req.opd8[op_req.opd16[2:0]];
        fm = FM_C;
      end
      default: begin
        fm = FM_NONE;
      end
    endcase
    if (nz_from_res) begin
      fv[F_N] = wide ? r16[15] : r8[7];
      fv[F_Z] = wide ? (r16 == 16'h0000) : (r8 == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Condition codes and interrupt gating
  always_comb begin
    ccr_nxt = ccr_r;
    shadow_nxt = shadow_r;
    if (insn_boundary) begin
      shadow_nxt = 1'b0;
    end
    if (state_r == ST_STACK && push_cnt_r == PUSH_LAST) begin
      ccr_nxt[F_I] = 1'b1;
    end else if (run_op) begin
      ccr_nxt = (ccr_r & ~fm) | (fv & fm);
      if (ccr_r[F_I] && !ccr_nxt[F_I]) begin
        shadow_nxt = 1'b1;
      end
    end else if (bus_wr && paddr == RA_CCR) begin
      ccr_nxt = pwdata[7:0];
    end
    ccr_nxt = ccr_nxt | CCR_ONES;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_r <= CCR_RST;
      shadow_r <= 1'b0;
      irq_ok_r <= 1'b0;
    end else begin
      ccr_r <= ccr_nxt;
      shadow_r <= shadow_nxt;
      // Gated from next values so a set mask never leaks a cycle
      irq_ok_r <= !ccr_nxt[F_I] && !shadow_nxt && (state_nxt == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working register and low pointer byte have no reset on purpose
  always_ff @(posedge pclk) begin
    if (run_op && a_wr) begin
      work_r <= r8;
    end else if (bus_wr && paddr == RA_WORK) begin
      work_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (run_op && hx_wr) begin
      plo_r <= r16[7:0];
    end else if (run_op && x_wr) begin
      plo_r <= r8;
    end else if (bus_wr && paddr == RA_PLO) begin
      plo_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phi_r <= HI_RST;
    end else if (run_op && hx_wr) begin
      phi_r <= r16[15:8];
    end else if (bus_wr && paddr == RA_PHI) begin
      phi_r <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: vector load after reset, interrupt stacking
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_VEC_HI: if (vec_rd_valid) state_nxt = ST_VEC_LO;
      ST_VEC_LO: if (vec_rd_valid) state_nxt = ST_RUN;
      ST_RUN: if (run_op && op_req.code == OP_IRQ) state_nxt = ST_STACK;
      ST_STACK: if (push_cnt_r == PUSH_LAST) state_nxt = ST_RUN;
      default: state_nxt = ST_VEC_HI;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_VEC_HI;
      push_cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      push_cnt_r <= (state_r == ST_STACK) ? push_cnt_r + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_r <= '0;
    end else if (state_r == ST_STACK) begin
      push_r.valid <= 1'b1;
      push_r.addr <= sp_r;
      case (push_cnt_r)
        3'h0: push_r.data <= pc_r[7:0];
        3'h1: push_r.data <= pc_r[15:8];
        3'h2: push_r.data <= plo_r;
        3'h3: push_r.data <= work_r;
        default: push_r.data <= ccr_r;
      endcase
    end else begin
      push_r.valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= SP_RST;
    end else if (state_r == ST_STACK) begin
      sp_r <= sp_r - 16'h0001;
    end else if (run_op && op_req.code == OP_AIS) begin
      sp_r <= sp_r + {{8{op_req.opd8[7]}}, op_req.opd8};
    end else if (run_op && op_req.code == OP_RSP) begin
      sp_r[7:0] <= SP_LOW_RELOAD;
    end else if (bus_wr && paddr == RA_SP) begin
      sp_r <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter
  always_comb begin
    case (op_req.code)
      OP_BRA: br_take = 1'b1;
      OP_BLT: br_take = ccr_r[F_N] ^ ccr_r[F_V];
      OP_BGE: br_take = !(ccr_r[F_N] ^ ccr_r[F_V]);
      default: br_take = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= 16'h0000;
    end else if (state_r == ST_VEC_HI && vec_rd_valid) begin
      pc_r[15:8] <= vec_rd_data;
    end else if (state_r == ST_VEC_LO && vec_rd_valid) begin
      pc_r[7:0] <= vec_rd_data;
    end else if (run_op && op_req.code == OP_FETCH) begin
      pc_r <= pc_r + 16'h0001;
    end else if (run_op && op_req.code == OP_JUMP) begin
      pc_r <= op_req.opd16;
    end else if (run_op && br_take) begin
      pc_r <= pc_r + {{8{op_req.opd8[7]}}, op_req.opd8};
    end else if (bus_wr && paddr == RA_PC) begin
      pc_r <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access cycle, unmapped offsets flag an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && (paddr > RA_STAT || paddr[1:0] != 2'b00);
      prdata_r <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          RA_WORK: prdata_r <= {24'h000000, work_r};
          RA_PHI: prdata_r <= {24'h000000, phi_r};
          RA_PLO: prdata_r <= {24'h000000, plo_r};
          RA_SP: prdata_r <= {16'h0000, sp_r};
          RA_PC: prdata_r <= {16'h0000, pc_r};
          RA_CCR: prdata_r <= {24'h000000, ccr_r};
          RA_STAT: prdata_r <= {26'h0, irq_ok_r, shadow_r, state_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign op_ready = (state_r == ST_RUN);
  assign vec_rd_req = (state_r == ST_VEC_HI) || (state_r == ST_VEC_LO);
  assign vec_rd_addr = (state_r == ST_VEC_LO) ? VEC_LO_ADDR : VEC_HI_ADDR;
  assign push = push_r;
  assign working_register = work_r;
  assign index_pointer = {phi_r, plo_r};
  assign stack_pointer = sp_r;
  assign program_counter = pc_r;
  assign condition_code_reg = ccr_r;
  assign irq_allowed = irq_ok_r;

endmodule

// >>> verif/cpr_regs_asserts.sv
// Property checker for the processor register set.
`timescale 1ns/10ps
module cpr_regs_chk
  import cpr_pkg::*;
(
  // Clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic op_valid,
  input wire cpr_req_t op_req,
  input wire logic op_ready,
  input wire logic insn_boundary,
  input wire logic vec_rd_req,
  input wire logic [15:0] vec_rd_addr,
  input wire logic vec_rd_valid,
  input wire logic [7:0] vec_rd_data,
  input wire cpr_push_t push,
  // Registers
  input wire logic [7:0] working_register,
  input wire logic [15:0] index_pointer,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] condition_code_reg,
  input wire logic irq_allowed
);
  logic take;
  cpr_op_t code;
  assign take = op_valid && op_ready;
  assign code = op_req.code;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  a_fixed_ones: assert property (condition_code_reg[6:5] == 2'b11)
    else $error("ccr ones");
  a_reset_sp: assert property ($rose(presetn) |-> stack_pointer == SP_RST)
    else $error("sp reset");
  a_reset_hi: assert property ($rose(presetn) |-> index_pointer[15:8] == HI_RST)
    else $error("hi reset");
  a_ais_adds: assert property (take && code == OP_AIS |=> stack_pointer ==
    $past(stack_pointer) + {{8{$past(op_req.opd8[7])}}, $past(op_req.opd8)})
    else $error("ais sum");
  a_rsp_low: assert property (take && code == OP_RSP |=>
    stack_pointer == {$past(stack_pointer[15:8]), SP_LOW_RELOAD}) else $error("rsp");
  a_jump_load: assert property (take && code == OP_JUMP |=>
    program_counter == $past(op_req.opd16)) else $error("jump");
  a_mask_gate: assert property (irq_allowed |-> !condition_code_reg[F_I])
    else $error("mask");
  a_unmask_hold: assert property (take && code == OP_CLI && condition_code_reg[F_I]
    && !insn_boundary |=> !irq_allowed) else $error("shadow");
  a_irq_push: assert property (take && code == OP_IRQ |-> ##2 (push.valid
    && push.addr == $past(stack_pointer, 2) && push.data == $past(program_counter[7:0], 2))
    ##1 (push.valid && push.data == $past(program_counter[15:8], 3))) else $error("push");
  a_irq_mask: assert property (take && code == OP_IRQ |=>
    $stable(condition_code_reg[F_I]) [*5] ##1 condition_code_reg[F_I]) else $error("irq");
  a_load_flags: assert property (take && code == OP_LDA |=>
    condition_code_reg[F_N] == working_register[7]
    && condition_code_reg[F_Z] == (working_register == 8'h00)) else $error("ld flags");
  c_irq: cover property (take && code == OP_IRQ);
  c_unmask: cover property (take && code == OP_CLI && condition_code_reg[F_I]);
  c_refused: cover property (pready && pslverr);
endmodule
////////////////////////////////////////////////////////////////
bind cpr_regs cpr_regs_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_req, .op_ready, .insn_boundary,
  .vec_rd_req, .vec_rd_addr, .vec_rd_valid, .vec_rd_data, .push, .working_register,
  .index_pointer, .stack_pointer, .program_counter, .condition_code_reg, .irq_allowed);

// >>> verif/tb.sv
// Self-checking bench for the processor register set with a reference model.
`timescale 1ns/10ps
module tb;
  import cpr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic op_valid = 1'b0, insn_boundary = 1'b0, vec_rd_valid = 1'b0;
  cpr_req_t op_req = '0;
  logic [7:0] vec_rd_data = 8'h00, working_register, condition_code_reg;
  logic pready, pslverr, op_ready, vec_rd_req, irq_allowed, err;
  logic [15:0] vec_rd_addr, index_pointer, stack_pointer, program_counter;
  cpr_push_t push;
  int miscompares = 0, checks = 0, cyc = 0, seed = 32'hd354;
  int a, x, h, sp, pc, cc, r, i;
  int q[$];
  int ev[6];
  int bcd[4] = '{8'h19, 8'h28, 8'h99, 8'h99};
  int stack_adjust_imm[3] = '{8'h7f, 8'h7f, 8'h80};
  logic [11:0] ad[6] = '{RA_WORK, RA_PHI, RA_PLO, RA_SP, RA_PC, RA_CCR};

  cpr_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_req, .op_ready, .insn_boundary, .vec_rd_req,
    .vec_rd_addr, .vec_rd_valid, .vec_rd_data, .push, .working_register, .index_pointer,
    .stack_pointer, .program_counter, .condition_code_reg, .irq_allowed);

  always #20 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic cmp_all();
    chk("work", working_register, a);
    chk("index", index_pointer, h * 256 + x);
    chk("sp", stack_pointer, sp);
    chk("pc", program_counter, pc);
    chk("ccr", condition_code_reg, cc);
  endtask

  function automatic void nz(int v, int m);
    cc = cc & 8'hf9 | ((v >> m & 1) << 2) | (v == 0 ? 2 : 0);
  endfunction

  // Reference model, one call per accepted operation
  function automatic void step(cpr_op_t c, int b, int w);
    int v;
    b = b & 255;
    w = w & 16'hffff;
    v = cc & 1;
    case (c)
      OP_ADD, OP_ADC: begin
        if (c == OP_ADD) v = 0;
        r = a + b + v;
        cc = cc & 8'h68 | ((a ^ r) & (b ^ r) & 128) | ((a & 15) + (b & 15) + v > 15 ? 16 : 0)
          | r >> 8;
        a = r & 255;
        nz(a, 7);
      end
      OP_SUB: begin
        r = a - b;
        cc = cc & 8'h78 | ((a ^ b) & (a ^ r) & 128) | (r < 0 ? 1 : 0);
        a = r & 255;
        nz(a, 7);
      end
      OP_DAA: begin
        v = (cc & 1) || a > 8'h99 ? 8'h60 : 0;
        if ((cc & 16) || (a & 15) > 9) v = v + 6;
        cc = cc | (v > 8'h5f ? 1 : 0);
        a = (a + v) & 255;
        nz(a, 7);
      end
      OP_LDA, OP_LDX: begin
        if (c == OP_LDA) a = b;
        else x = b;
        cc = cc & 8'h7f;
        nz(b, 7);
      end
      OP_LSLX, OP_ROLX: begin
        r = x * 2 + (c == OP_ROLX ? v : 0);
        x = r & 255;
        cc = cc & 8'h7e | (r >> 8) | (((r >> 8) ^ (x >> 7)) << 7);
        nz(x, 7);
      end
      OP_BITTST: cc = cc & 8'hfe | (b >> (w & 7) & 1);
      OP_BLT, OP_BGE: if (((cc >> 2 ^ cc >> 7) & 1) == (c == OP_BLT))
        pc = (pc + b - (b > 127 ? 256 : 0)) & 16'hffff;
      OP_TAP: cc = a | 8'h60;
      OP_LDHX: begin
        h = w >> 8;
        x = w & 255;
        cc = cc & 8'h7f;
        nz(w, 15);
      end
      OP_INCX: begin
        x = (x + 1) & 255;
        cc = cc & 8'h7f | (x == 128 ? 128 : 0);
        nz(x, 7);
      end
      OP_CLRX: begin
        x = 0;
        cc = cc & 8'h7f;
        nz(x, 7);
      end
      OP_AIS: sp = (sp + b - (b > 127 ? 256 : 0)) & 16'hffff;
      OP_RSP: sp = sp & 16'hff00 | 255;
      OP_FETCH: pc = (pc + 1) & 16'hffff;
      OP_JUMP: pc = w;
      OP_SEI: cc = cc | 8;
      OP_CLI: cc = cc & 8'hf7;
      default: ;
    endcase
  endfunction

  task automatic op(cpr_op_t c, int b, int w);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_req <= '{c, b[7:0], w[15:0]};
    do @(posedge pclk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    @(negedge pclk);
    step(c, b, w);
    if (c != OP_IRQ) cmp_all();
  endtask

  // Request held until pready is seen high
  task automatic apb(logic w, logic [11:0] adr, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= adr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic boot(int v);
    int k;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("rsp", stack_pointer, 16'h00ff);
    chk("rhi", index_pointer[15:8], 8'h00);
    chk("rccr", condition_code_reg, 8'h68);
    @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 2; k++) begin
      @(negedge pclk);
      chk("vaddr", vec_rd_addr, 16'hfffe + k);
      chk("vreq", vec_rd_req, 1'b1);
      @(posedge pclk);
      vec_rd_valid <= 1'b1;
      vec_rd_data <= 8'(v >> (8 - 8 * k));
      @(posedge pclk);
      vec_rd_valid <= 1'b0;
    end
    do @(negedge pclk); while (op_ready !== 1'b1);
    pc = v & 16'hffff;
    sp = 16'h00ff;
    h = 0;
    cc = 8'h68;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    boot($random(seed));
    a = $random(seed) & 255;
    h = $random(seed) & 255;
    x = $random(seed) & 255;
    sp = $random(seed) & 16'hffff;
    ev = '{a, h, x, sp, pc, 8'h60};
    for (i = 0; i < 4; i++) apb(1'b1, ad[i], ev[i]);
    apb(1'b1, RA_CCR, 32'h0);
    cc = 8'h60;
    apb(1'b1, 12'h01c, 32'hffffffff);
    chk("werr", err, 1'b1);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk("rdata", rd, ev[i]);
      chk("rerr", err, 1'b0);
    end
    apb(1'b0, 12'h006, 32'h0);
    chk("merr", err, 1'b1);
    chk("mdata", rd, 32'h0);
    op(OP_LDHX, 0, 16'h12ff);
    op(OP_INCX, 0, 0);
    op(OP_CLRX, 0, 0);
    for (i = 0; i < 24; i++) begin
      op(OP_LDA, $random(seed), 0);
      op(i % 3 == 0 ? OP_SUB : i % 3 == 1 ? OP_ADD : OP_ADC, $random(seed), 0);
      op(i % 2 ? OP_BLT : OP_BGE, $random(seed), 0);
      op(OP_LDX, $random(seed), 0);
      op(i % 2 ? OP_ROLX : OP_LSLX, 0, 0);
      op(OP_BITTST, $random(seed), $random(seed));
    end
    for (i = 0; i < 4; i += 2) begin
      op(OP_LDA, bcd[i], 0);
      op(OP_ADD, bcd[i + 1], 0);
      op(OP_DAA, 0, 0);
    end
    op(OP_TAP, 0, 0);
    for (i = 0; i < 3; i++) op(OP_AIS, stack_adjust_imm[i], 0);
    op(OP_RSP, 0, 0);
    op(OP_FETCH, 0, 0);
    op(OP_JUMP, 0, $random(seed));
    op(OP_FETCH, 0, 0);
    op(OP_NOP, 0, 0);
    op(OP_SEI, 0, 0);
    chk("irq_set", irq_allowed, 1'b0);
    op(OP_CLI, 0, 0);
    chk("irq_cli", irq_allowed, 1'b0);
    @(posedge pclk);
    insn_boundary <= 1'b1;
    @(posedge pclk);
    insn_boundary <= 1'b0;
    @(negedge pclk);
    chk("irq_ok", irq_allowed, 1'b1);
    // Stacked image is taken before the mask goes up
    q = '{pc & 255, pc >> 8, x, a, cc};
    op(OP_IRQ, 0, 0);
    for (i = 0; i < 10; i++) begin
      @(negedge pclk);
      if (push.valid === 1'b1) begin
        chk("paddr", push.addr, sp);
        chk("pdata", push.data, q.pop_front());
        sp = (sp - 1) & 16'hffff;
      end
    end
    chk("pcount", q.size(), 0);
    cc = cc | 8;
    cmp_all();
    chk("irq_in", irq_allowed, 1'b0);
    boot($random(seed));
    cmp_all();
    wrap_up();
  end
endmodule
